// *** tb/paged_register_map_test.sv ***
/*
 * self-checking bench of the paged register map, device side.
 * assumes: pmap_host_model plays the host; mclk at 10 MHz.
 */
`timescale 1ns/1ps
`include "pmap_defs.svh"

module paged_register_map_test;
  logic mclk, rst, conv_valid, pen_down, adc_idle;
  logic [`PMAP_IDX_W-1:0] conv_idx;
  logic [`PMAP_RES_W-1:0] conv_data;
  logic sclk, ss_n, mosi, miso, miso_oe;
  logic [15:0] touch_ctrl;
  int errors, comparisons;

  pmap_host_model host
  (
    .mclk(mclk), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe)
  );

  pmap_paged_regs dut
  (
    .mclk(mclk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .conv_valid(conv_valid),
    .conv_idx(conv_idx), .conv_data(conv_data), .pen_down(pen_down),
    .adc_idle(adc_idle), .touch_ctrl(touch_ctrl)
  );

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************
  // helpers
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] cw(input logic r, input logic [3:0] pg,
    input logic [5:0] a);
    return {r, pg, a, 5'h00};
  endfunction

  // msb set so a left-shifted result shows
  function automatic logic [11:0] dv(input int j);
    return 12'h8A0 | 12'(j);
  endfunction

  function automatic logic ok(input int j);
    return j < 11 && j != 4 && j != 8;
  endfunction

  task automatic conv(input logic [5:0] idx, input logic [11:0] d);
    @(posedge mclk);
    conv_valid <= 1'b1;
    conv_idx <= idx;
    conv_data <= d;
    @(posedge mclk);
    conv_valid <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr1(input logic [15:0] c, input logic [15:0] v);
    host.wq[0] = v;
    host.frame(c, 1, 0);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    check(touch_ctrl, 16'h0000);
    host.frame(cw(1'b1, 4'h0, 6'h00), 11, 0);
    check({15'h0000, host.oe_ok}, 16'h0001);
    check({15'h0000, miso_oe}, 16'h0000);
    for (int j = 0; j < 11; j++)
      check(host.rq[j], 16'h0000);
  endtask

  // reserved slots 04, 08 and 0B are fed too and must stay zero
  task automatic t_results();
    for (int j = 0; j < 12; j++)
      conv(6'(j), dv(j));
    repeat (2)
    begin
      host.frame(cw(1'b1, 4'h0, 6'h00), 12, 0);
      for (int j = 0; j < 12; j++)
        check(host.rq[j], ok(j) ? {4'h0, dv(j)} : 16'h0000);
    end
    conv(6'h01, 12'h7FF);
    host.frame(cw(1'b1, 4'h0, 6'h01), 2, 0);
    check(host.rq[0], 16'h07FF);
    check(host.rq[1], {4'h0, dv(2)});
    wr1(cw(1'b0, 4'h0, 6'h00), 16'hFFFF);
    host.frame(16'h801F, 1, 0);
    check(host.rq[0], {4'h0, dv(0)});
  endtask

  task automatic t_ctrl();
    pen_down <= 1'b1;
    wr1(cw(1'b0, 4'h1, 6'h00), 16'h1234);
    check(touch_ctrl, 16'h1234);
    host.frame(cw(1'b1, 4'h1, 6'h00), 1, 0);
    check(host.rq[0], 16'h9234);
    pen_down <= 1'b0;
    adc_idle <= 1'b1;
    host.wq[0] = 16'hABCD;
    host.frame(cw(1'b0, 4'h1, 6'h00), 0, 8);
    host.frame(cw(1'b1, 4'h1, 6'h00), 1, 0);
    check(host.rq[0], 16'h5234);
    check(touch_ctrl, 16'h1234);
  endtask

  task automatic t_bursts();
    host.wq[0] = 16'hAAAA;
    host.wq[1] = 16'h5555;
    host.wq[2] = 16'h0F0F;
    host.wq[3] = 16'h3C3C;
    host.frame(cw(1'b0, 4'h2, 6'h00), 3, 0);
    host.frame(cw(1'b0, 4'h2, 6'h1D), 4, 0);
    host.frame(cw(1'b1, 4'h2, 6'h00), 3, 0);
    check(host.rq[0], 16'hAAAA);
    check(host.rq[1], 16'h0000);
    check(host.rq[2], 16'h0F0F);
    host.frame(cw(1'b1, 4'h2, 6'h1D), 4, 0);
    check(host.rq[0], 16'hAAAA);
    check(host.rq[2], 16'h0000);
    check(host.rq[3], 16'hFFFF);
    host.frame(cw(1'b1, 4'h2, 6'h20), 1, 0);
    check(host.rq[0], 16'hFFFF);
    wr1(cw(1'b0, 4'h1, 6'h02), 16'hFFFF);
    host.frame(cw(1'b1, 4'h1, 6'h02), 1, 0);
    check(host.rq[0], 16'h0000);
    for (int p = 3; p < 16; p++)
    begin
      wr1(cw(1'b0, 4'(p), 6'h00), 16'hFFFF);
      host.frame(cw(1'b1, 4'(p), 6'h00), 1, 0);
      check(host.rq[0], 16'h0000);
    end
  endtask

  // a mid-run reset clears results and control pages alike
  task automatic t_rerun();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check(touch_ctrl, 16'h0000);
    host.frame(cw(1'b1, 4'h0, 6'h00), 1, 0);
    check(host.rq[0], 16'h0000);
  endtask

  initial
  begin
    rst = 1'b1;
    conv_valid = 1'b0;
    conv_idx = 6'h00;
    conv_data = 12'h000;
    pen_down = 1'b0;
    adc_idle = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset();
    t_results();
    t_ctrl();
    t_bursts();
    t_rerun();
    give_verdict();
  end

  // the whole run needs some 13k cycles
  initial
  begin
    #4_000_000;
    errors++;
    give_verdict();
  end
endmodule

// *** tb/pmap_host_model.sv ***
/*
 * host model: serial master, idle-low clock, drives on the rise and
 * samples on the fall, three mclk to each clock half.
 * assumes: the bench runs frame() by hierarchical call.
 */
`timescale 1ns/1ps

module pmap_host_model
(
  input wire logic mclk,
  output logic sclk,
  output logic ss_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic [15:0] wq [16];
  logic [15:0] rq [16];
  logic [15:0] cq;
  logic oe_ok;

  initial
  begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    foreach (wq[k])
      wq[k] = 16'h0000;
  end

  // ****************
  // bit and frame
  // ****************
  // msb first
  task automatic shift(input logic [15:0] tx, input int nb,
    output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - nb; i--)
    begin
      @(posedge mclk);
      sclk <= 1'b1;
      mosi <= tx[i];
      repeat (3) @(posedge mclk);
      rx[i] = miso;
      oe_ok &= miso_oe;
      sclk <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask

  task automatic frame(input logic [15:0] cmd, input int n,
    input int tail);
    logic [15:0] junk;
    oe_ok = 1'b1;
    @(posedge mclk);
    ss_n <= 1'b0;
    repeat (3) @(posedge mclk);
    shift(cmd, 16, cq);
    for (int k = 0; k < n; k++)
      shift(wq[k], 16, rq[k]);
    // a nonzero tail leaves a partial word, so the frame is cut short
    if (tail > 0)
      shift(wq[n], tail, junk);
    repeat (2) @(posedge mclk);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (3) @(posedge mclk);
  endtask
endmodule

// *** verilog/pmap_bank_if.sv ***
/*
 * link between the serial front end and the page zero result bank.
 * assumes: both ends run on the same clock; rd_data is combinational.
 */
`timescale 1ns/1ps
`include "pmap_defs.svh"

interface pmap_bank_if;
  logic conv_valid;
  logic [`PMAP_IDX_W-1:0] conv_idx;
  logic [`PMAP_RES_W-1:0] conv_data;
  logic [`PMAP_IDX_W-1:0] rd_idx;
  logic [`PMAP_WORD_W-1:0] rd_data;

  modport bank
  (
    input conv_valid,
    input conv_idx,
    input conv_data,
    input rd_idx,
    output rd_data
  );

  modport ctrl
  (
    output conv_valid,
    output conv_idx,
    output conv_data,
    output rd_idx,
    input rd_data
  );
endinterface

// *** verilog/pmap_defs.svh ***
/*
 * named offsets, field positions and fixed words of the paged register map.
 * assumes: included by bare name wherever a number is needed.
 */
`ifndef PMAP_DEFS_SVH
`define PMAP_DEFS_SVH

// ****************************************************************
// widths and command word layout
// ****************************************************************
`define PMAP_WORD_W 16
`define PMAP_RES_W 12
`define PMAP_IDX_W 6
`define PMAP_PG_W 4
`define PMAP_CMD_RW 15
`define PMAP_CMD_PG_HI 14
`define PMAP_CMD_PG_LO 11
`define PMAP_CMD_AD_HI 10
`define PMAP_CMD_AD_LO 5
`define PMAP_BIT_LAST 4'hF
`define PMAP_BIT_FIRST 4'h0

// ****************************************************************
// pages and fixed answers
// ****************************************************************
`define PMAP_PAGE_RES 4'h0
`define PMAP_PAGE_TSC 4'h1
`define PMAP_PAGE_AUD 4'h2
`define PMAP_LAST_IDX 6'h1F
`define PMAP_PAGE_DEPTH 32
`define PMAP_PAST_END 16'hFFFF
`define PMAP_ZERO_WORD 16'h0000
`define PMAP_RES_PAD 4'h0
`define PMAP_RES_SLOTS 11

// ****************************************************************
// page zero result offsets
// ****************************************************************
`define PMAP_HORIZ_OFS 6'h00
`define PMAP_VERT_OFS 6'h01
`define PMAP_PRESS1_OFS 6'h02
`define PMAP_PRESS2_OFS 6'h03
`define PMAP_CELL1_OFS 6'h05
`define PMAP_CELL2_OFS 6'h06
`define PMAP_SPARE_OFS 6'h07
`define PMAP_THERM1_OFS 6'h09
`define PMAP_THERM2_OFS 6'h0A

// ****************************************************************
// page one and page two offsets
// ****************************************************************
`define PMAP_TSC_ADC_OFS 6'h00
`define PMAP_TSC_STAT_OFS 6'h01
`define PMAP_TSC_REF_OFS 6'h03
`define PMAP_TSC_RST_OFS 6'h04
`define PMAP_TSC_CFG_OFS 6'h05
`define PMAP_AUD_CTL1_OFS 6'h00
`define PMAP_AUD_VOL_OFS 6'h02
`define PMAP_AUD_LO_OFS 6'h04
`define PMAP_AUD_HI_OFS 6'h1D
`define PMAP_PEN_BIT 15
`define PMAP_IDLE_BIT 14

`endif

// *** verilog/pmap_paged_regs.sv ***
/*
 * paged register map behind a serial slave port, device side.
 * assumes: sclk, ss_n, mosi are synchronous to mclk and sclk runs at
 * no more than a quarter of mclk; mode is idle-low clock, data taken
 * on the falling edge and driven on the rising edge.
 */
`timescale 1ns/1ps
`include "pmap_defs.svh"

module pmap_paged_regs
  import pmap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic conv_valid,
  input wire logic [`PMAP_IDX_W-1:0] conv_idx,
  input wire logic [`PMAP_RES_W-1:0] conv_data,
  input wire logic pen_down,
  input wire logic adc_idle,
  output logic [`PMAP_WORD_W-1:0] touch_ctrl
);

  pmap_ctl_t s_ff;
  pmap_ctl_t nxt_s;
  pmap_bank_if bus ();
  logic sclk_rise;
  logic sclk_fall;
  pmap_word_t rx_full;

  pmap_result_bank u_bank
  (
    .mclk(mclk),
    .rst(rst),
    .bus(bus.bank)
  );

  assign bus.conv_valid = conv_valid;
  assign bus.conv_idx = conv_idx;
  assign bus.conv_data = conv_data;
  // read source follows the registered pointer; load is one cycle later
  assign bus.rd_idx = s_ff.ptr;

  assign sclk_rise = sclk & ~s_ff.sclk_prev;
  assign sclk_fall = ~sclk & s_ff.sclk_prev;
  assign rx_full = {s_ff.rx_sh[`PMAP_WORD_W-2:0], mosi};

  assign miso = s_ff.miso;
  assign miso_oe = s_ff.miso_oe;
  assign touch_ctrl = s_ff.pg1[`PMAP_TSC_ADC_OFS];

  // ****************************************************************
  // address map
  // ****************************************************************
  function automatic logic tsc_valid(input logic [`PMAP_IDX_W-1:0] a);
    return a == `PMAP_TSC_ADC_OFS || a == `PMAP_TSC_STAT_OFS ||
           a == `PMAP_TSC_REF_OFS || a == `PMAP_TSC_RST_OFS ||
           a == `PMAP_TSC_CFG_OFS;
  endfunction

  function automatic logic aud_valid(input logic [`PMAP_IDX_W-1:0] a);
    return a == `PMAP_AUD_CTL1_OFS || a == `PMAP_AUD_VOL_OFS ||
           (a >= `PMAP_AUD_LO_OFS && a <= `PMAP_AUD_HI_OFS);
  endfunction

  function automatic pmap_word_t rd_word(
    input logic [`PMAP_PG_W-1:0] pg,
    input logic [`PMAP_IDX_W-1:0] a,
    input logic pe,
    input pmap_word_t r0,
    input pmap_word_t w1,
    input pmap_word_t w2,
    input logic pen,
    input logic idle);
    pmap_word_t w;
    w = `PMAP_ZERO_WORD;
    // beyond page end reads all ones
    if (pe || a > `PMAP_LAST_IDX)
    begin
      w = `PMAP_PAST_END;
    end
    else
    begin
      // page select; reserved pages read zero
      case (pg)
        `PMAP_PAGE_RES: w = r0;
        `PMAP_PAGE_TSC:
        begin
          // status replaces control bits on read
          if (a == `PMAP_TSC_ADC_OFS)
          begin
            w = {pen, idle, w1[`PMAP_IDLE_BIT-1:0]};
          end
          else if (tsc_valid(a))
          begin
            w = w1;
          end
        end
        `PMAP_PAGE_AUD:
        begin
          if (aud_valid(a))
          begin
            w = w2;
          end
        end
        default: w = `PMAP_ZERO_WORD;
      endcase
    end
    return w;
  endfunction

  // ****************************************************************
  // serial frame and register access
  // ****************************************************************
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.sclk_prev = sclk;
    nxt_s.miso_oe = !ss_n;
    if (ss_n)
    begin
      nxt_s.st = PMAP_ST_IDLE;
      nxt_s.load_pend = 1'b0;
    end
    else
    begin
      case (s_ff.st)
        PMAP_ST_IDLE:
        begin
          // a fresh select always starts with a command word
          nxt_s.st = PMAP_ST_CMD;
          nxt_s.bit_cnt = `PMAP_BIT_FIRST;
          nxt_s.tx_sh = `PMAP_ZERO_WORD;
          nxt_s.past_end = 1'b0;
        end
        PMAP_ST_CMD, PMAP_ST_DATA:
        begin
          if (sclk_rise)
          begin
            nxt_s.miso = s_ff.tx_sh[`PMAP_WORD_W-1];
            nxt_s.tx_sh = {s_ff.tx_sh[`PMAP_WORD_W-2:0], 1'b0};
          end
          if (s_ff.load_pend)
          begin
            nxt_s.load_pend = 1'b0;
            nxt_s.tx_sh = rd_word(s_ff.page, s_ff.ptr, s_ff.past_end,
              bus.rd_data, s_ff.pg1[s_ff.ptr[4:0]],
              s_ff.pg2[s_ff.ptr[4:0]], pen_down, adc_idle);
          end
          if (sclk_fall)
          begin
            nxt_s.rx_sh = rx_full;
            nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
            if (s_ff.bit_cnt == `PMAP_BIT_LAST)
            begin
              nxt_s.load_pend = 1'b1;
              nxt_s.st = PMAP_ST_DATA;
              if (s_ff.st == PMAP_ST_CMD)
              begin
                nxt_s.rd_mode = rx_full[`PMAP_CMD_RW];
                nxt_s.page = rx_full[`PMAP_CMD_PG_HI:`PMAP_CMD_PG_LO];
                nxt_s.ptr = rx_full[`PMAP_CMD_AD_HI:`PMAP_CMD_AD_LO];
                nxt_s.past_end = 1'b0;
              end
              else
              begin
                if (!s_ff.rd_mode && !s_ff.past_end &&
                    s_ff.ptr <= `PMAP_LAST_IDX)
                begin
                  // page zero and reserved pages take no writes
                  if (s_ff.page == `PMAP_PAGE_TSC && tsc_valid(s_ff.ptr))
                  begin
                    nxt_s.pg1[s_ff.ptr[4:0]] = rx_full;
                  end
                  if (s_ff.page == `PMAP_PAGE_AUD && aud_valid(s_ff.ptr))
                  begin
                    nxt_s.pg2[s_ff.ptr[4:0]] = rx_full;
                  end
                end
                // advance up to the last location
                if (s_ff.ptr >= `PMAP_LAST_IDX)
                begin
                  nxt_s.past_end = 1'b1;
                end
                else
                begin
                  nxt_s.ptr = s_ff.ptr + 6'h01;
                end
              end
            end
          end
        end
        default: nxt_s.st = PMAP_ST_IDLE;
      endcase
    end
    if (rst)
    begin
      nxt_s = '0;
      nxt_s.st = PMAP_ST_IDLE;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_ff <= nxt_s;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_word_end;
    !ss_n && sclk_fall && s_ff.bit_cnt == `PMAP_BIT_LAST;
  endsequence

  sequence s_cmd_end;
    s_word_end ##0 s_ff.st == PMAP_ST_CMD;
  endsequence

  sequence s_load;
    !ss_n && s_ff.load_pend && s_ff.st == PMAP_ST_DATA;
  endsequence

  chk_cmd_decode: assert property (
    s_cmd_end |=> s_ff.st == PMAP_ST_DATA &&
      s_ff.rd_mode == $past(s_ff.rx_sh[`PMAP_CMD_RW-1]) &&
      s_ff.page == $past(rx_full[`PMAP_CMD_PG_HI:`PMAP_CMD_PG_LO]))
    else $error("command word decoded wrongly");

  chk_ptr_advance: assert property (
    s_word_end ##0 s_ff.st == PMAP_ST_DATA &&
      s_ff.ptr < `PMAP_LAST_IDX && !s_ff.past_end
    |=> s_ff.ptr == $past(s_ff.ptr) + 6'h01 ##1 !s_ff.load_pend)
    else $error("pointer did not advance");

  chk_past_end_ones: assert property (
    s_load ##0 s_ff.past_end |=> s_ff.tx_sh == `PMAP_PAST_END)
    else $error("read past page end not all ones");

  chk_status_read: assert property (
    s_load ##0 s_ff.page == `PMAP_PAGE_TSC &&
      s_ff.ptr == `PMAP_TSC_ADC_OFS && !s_ff.past_end
    |=> s_ff.tx_sh[`PMAP_PEN_BIT] == $past(pen_down) &&
      s_ff.tx_sh[`PMAP_IDLE_BIT] == $past(adc_idle))
    else $error("status bits not returned on read");

  chk_page0_readonly: assert property (
    s_ff.page == `PMAP_PAGE_RES |=> $stable(s_ff.pg1) && $stable(s_ff.pg2))
    else $error("write to result page changed a control page");

  chk_audio_write: assert property (
    s_word_end ##0 s_ff.st == PMAP_ST_DATA && !s_ff.rd_mode &&
      !s_ff.past_end && s_ff.page == `PMAP_PAGE_AUD &&
      s_ff.ptr == `PMAP_AUD_VOL_OFS
    |=> s_ff.pg2[`PMAP_AUD_VOL_OFS] == $past(rx_full))
    else $error("audio page write lost");

  chk_miso_shift: assert property (
    !ss_n && s_ff.st != PMAP_ST_IDLE && sclk_rise && !s_ff.load_pend
    |=> miso == $past(s_ff.tx_sh[`PMAP_WORD_W-1]) && miso_oe)
    else $error("output bit not shifted on rising edge");

  chk_reset_ctrl: assert property (
    $fell(rst) |-> s_ff.pg1 == '0 && s_ff.pg2 == '0 && !s_ff.miso_oe)
    else $error("control pages not cleared by reset");

endmodule

// *** verilog/pmap_pkg.sv ***
/*
 * types of the paged register map: state enum and state records.
 * assumes: pmap_defs.svh is on the include path.
 */
`include "pmap_defs.svh"

package pmap_pkg;

  // ****************************************************************
  // serial frame states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    PMAP_ST_IDLE = 3'h1,
    PMAP_ST_CMD = 3'h2,
    PMAP_ST_DATA = 3'h4
  } pmap_state_t;

  typedef logic [`PMAP_WORD_W-1:0] pmap_word_t;

  typedef struct packed
  {
    pmap_state_t st;
    logic sclk_prev;
    logic [3:0] bit_cnt;
    pmap_word_t rx_sh;
    pmap_word_t tx_sh;
    logic rd_mode;
    logic [`PMAP_PG_W-1:0] page;
    logic [`PMAP_IDX_W-1:0] ptr;
    logic past_end;
    logic load_pend;
    logic miso;
    logic miso_oe;
    logic [`PMAP_PAGE_DEPTH-1:0][`PMAP_WORD_W-1:0] pg1;
    logic [`PMAP_PAGE_DEPTH-1:0][`PMAP_WORD_W-1:0] pg2;
  } pmap_ctl_t;

  typedef struct packed
  {
    logic [`PMAP_RES_SLOTS-1:0][`PMAP_RES_W-1:0] res;
  } pmap_bank_t;

endpackage

// *** verilog/pmap_result_bank.sv ***
/*
 * page zero: read-only conversion result registers, 12-bit right-justified.
 * assumes: the converter presents one result per conv_valid pulse.
 */
`timescale 1ns/1ps
`include "pmap_defs.svh"

module pmap_result_bank
  import pmap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  pmap_bank_if.bank bus
);

  pmap_bank_t s_ff;
  pmap_bank_t nxt_s;

  function automatic logic is_result(input logic [`PMAP_IDX_W-1:0] a);
    return a == `PMAP_HORIZ_OFS || a == `PMAP_VERT_OFS ||
           a == `PMAP_PRESS1_OFS || a == `PMAP_PRESS2_OFS ||
           a == `PMAP_CELL1_OFS || a == `PMAP_CELL2_OFS ||
           a == `PMAP_SPARE_OFS || a == `PMAP_THERM1_OFS ||
           a == `PMAP_THERM2_OFS;
  endfunction

  // ****************************************************************
  // result storage
  // ****************************************************************
  always_comb
  begin
    // slots change only on a conversion or on reset
    nxt_s = s_ff;
    if (bus.conv_valid && is_result(bus.conv_idx))
    begin
      nxt_s.res[bus.conv_idx[3:0]] = bus.conv_data;
    end
    if (rst)
    begin
      nxt_s = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_ff <= nxt_s;
  end

  // upper nibble zero, reserved reads zero
  assign bus.rd_data = is_result(bus.rd_idx) ?
    {`PMAP_RES_PAD, s_ff.res[bus.rd_idx[3:0]]} : `PMAP_ZERO_WORD;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_upper_nibble_zero: assert property (
    bus.rd_data[`PMAP_WORD_W-1:`PMAP_RES_W] == `PMAP_RES_PAD)
    else $error("result upper bits not zero");

  chk_result_store: assert property (
    bus.conv_valid && bus.conv_idx == `PMAP_THERM2_OFS
    |=> s_ff.res[`PMAP_RES_SLOTS-1] == $past(bus.conv_data))
    else $error("result not stored at its offset");

  chk_result_hold: assert property (
    !bus.conv_valid |=> $stable(s_ff.res))
    else $error("result changed without a conversion");

  chk_reserved_zero: assert property (
    !is_result(bus.rd_idx) |-> bus.rd_data == `PMAP_ZERO_WORD)
    else $error("reserved result slot not zero");

  // looked at on the first edge out of reset, where the check is enabled
  chk_reset_zero: assert property (@(posedge mclk)
    $fell(rst) |-> s_ff.res == '0)
    else $error("results not cleared by reset");

endmodule
